//--- common/b2ds_if.sv
`timescale 1ns/1ps
// pins between the memory device and its controller
interface b2ds_if #(
  parameter int DATA_W = b2ds_pkg::B2DS_DATA_W_WIDE,
  parameter int ADDR_W = b2ds_pkg::B2DS_ADDR_W
);
  localparam int LANES = DATA_W / b2ds_pkg::B2DS_LANE_W;
  logic              cycle_start_n;       // operation load, active low
  logic              access_dir;          // 1 read, 0 write
  logic [ADDR_W-1:0] addr;                // shared address bus
  logic [LANES-1:0]  byte_lane_wr_sel_n;  // lane write selects, active low
  logic              half_phase;          // 0 main edge word, 1 inverted edge word
  logic [DATA_W-1:0] dq_ctl_o;            // controller drive value
  logic              dq_ctl_oe_n;         // controller enable, low drives
  logic [DATA_W-1:0] dq_dev_o;            // device drive value
  logic              dq_dev_oe_n;         // device enable, low drives
  logic              out_valid_flag;      // read data valid
  logic              echo_timing_out;     // echo clock
  logic              pll_off_n;           // pll off, active low
  // resolved shared bus level
  logic [DATA_W-1:0] dq;
  assign dq = !dq_dev_oe_n ? dq_dev_o : (!dq_ctl_oe_n ? dq_ctl_o : '0);

  modport device (
    input  cycle_start_n, access_dir, addr, byte_lane_wr_sel_n, half_phase,
    input  dq, pll_off_n,
    output dq_dev_o, dq_dev_oe_n, out_valid_flag, echo_timing_out
  );
  modport ctrl (
    output cycle_start_n, access_dir, addr, byte_lane_wr_sel_n, half_phase,
    output dq_ctl_o, dq_ctl_oe_n, pll_off_n,
    input  dq, out_valid_flag, echo_timing_out
  );
endinterface : b2ds_if

//--- common/b2ds_pkg.sv
// shared constants and types for the two-word burst memory port
package b2ds_pkg;
  // default data width (wide configuration) and narrow alternative
  localparam int B2DS_DATA_W_WIDE   = 36;
  localparam int B2DS_DATA_W_NARROW = 18;
  // bits gated by one byte-lane select
  localparam int B2DS_LANE_W        = 9;
  // words per burst
  localparam int B2DS_BURST_LEN     = 2;
  // default address width kept small for simulation
  localparam int B2DS_ADDR_W        = 8;
  // read latency in half cycles (2.5 cycles) with pll on
  localparam int B2DS_RD_LAT_HALF   = 5;
  // read latency in half cycles with pll off (one cycle)
  localparam int B2DS_RD_LAT_HALF_OFF = 2;
  // fifo depth on the controller's read path
  localparam int B2DS_FIFO_DEPTH    = 16;
  // echo clock reset level
  localparam logic B2DS_ECHO_RST    = 1'b0;

  // controller sequencer states
  typedef enum logic [1:0] {
    B2DS_IDLE,
    B2DS_WR2,
    B2DS_RDWAIT
  } b2ds_ctl_state_type;
endpackage : b2ds_pkg

//--- verification/b2ds_chk.sv
`timescale 1ns/1ps
// watches the pins between the two ends
module b2ds_chk (
  input wire logic clk,             // half-cycle clock
  input wire logic rst,             // sync reset
  input wire logic cycle_start_n,   // load strobe
  input wire logic access_dir,      // 1 read
  input wire logic half_phase,      // edge slot
  input wire logic dq_ctl_oe_n,     // controller drive enable
  input wire logic dq_dev_oe_n,     // device drive enable
  input wire logic out_valid_flag,  // read valid
  input wire logic echo_timing_out, // echo clock
  input wire logic pll_off_n        // pll off
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_load_gap;
    !cycle_start_n |=> cycle_start_n;
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("load inside burst");
  property p_load_main;
    !cycle_start_n |-> !half_phase;
  endproperty
  a_load_main: assert property (p_load_main) else $error("load off main edge");
  property p_wr_burst;
    !cycle_start_n && !access_dir |->
      !dq_ctl_oe_n ##1 !dq_ctl_oe_n ##1 (dq_ctl_oe_n || !cycle_start_n);
  endproperty
  a_wr_burst: assert property (p_wr_burst) else $error("write burst length");
  property p_rd_lat;
    !cycle_start_n && access_dir && pll_off_n |->
      !out_valid_flag [*6] ##1 out_valid_flag [*2] ##1 !out_valid_flag;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency pll on");
  property p_rd_lat_off;
    !cycle_start_n && access_dir && !pll_off_n |->
      !out_valid_flag [*3] ##1 out_valid_flag [*2] ##1 !out_valid_flag;
  endproperty
  a_rd_lat_off: assert property (p_rd_lat_off) else $error("read latency pll off");
  property p_rd_drive;
    out_valid_flag |-> !dq_dev_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read word not driven");
  property p_release;
    !out_valid_flag |-> dq_dev_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("device drives when idle");
  property p_no_clash;
    !(!dq_ctl_oe_n && !dq_dev_oe_n);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus contention");
  property p_echo;
    echo_timing_out == $past(half_phase);
  endproperty
  a_echo: assert property (p_echo) else $error("echo clock off phase");
endmodule // b2ds_chk

//--- verification/testbench.sv
`timescale 1ns/1ps
// counts each comparison and reports any mismatch
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import b2ds_pkg::*;
  localparam int DW = B2DS_DATA_W_WIDE;
  localparam int LN = DW / B2DS_LANE_W;
  logic                   clk = 1'b0;      // 40 mhz
  logic                   rst = 1'b1;      // held at start
  logic                   pll_enable = 1'b1;
  logic                   req_valid = 1'b0;
  logic                   req_ready;
  logic                   req_read = 1'b0;
  logic [B2DS_ADDR_W-1:0] req_addr = '0;
  logic [2*DW-1:0]        req_wdata = '0;
  logic [2*LN-1:0]        req_wsel_n = '1;
  logic                   rd_valid;
  logic                   rd_ready = 1'b1;
  logic [DW-1:0]          rd_data;
  logic [DW-1:0]          mem0;            // expected word0 at address 5
  logic [DW-1:0]          mem1;            // expected word1 at address 5
  int                     n_fail = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  b2ds_if #(.DATA_W(DW)) pins ();
  b2ds_device #(.DATA_W(DW)) i_b2ds_device (.clk(clk), .rst(rst), .ce(1'b1),
    .pins(pins.device));
  b2ds_ctrl #(.DATA_W(DW)) i_b2ds_ctrl (.clk(clk), .rst(rst), .ce(1'b1),
    .pll_enable(pll_enable), .req_valid(req_valid), .req_ready(req_ready),
    .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_wsel_n(req_wsel_n), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .pins(pins.ctrl));
  b2ds_chk i_b2ds_chk (.clk(clk), .rst(rst), .cycle_start_n(pins.cycle_start_n),
    .access_dir(pins.access_dir), .half_phase(pins.half_phase),
    .dq_ctl_oe_n(pins.dq_ctl_oe_n), .dq_dev_oe_n(pins.dq_dev_oe_n),
    .out_valid_flag(pins.out_valid_flag), .echo_timing_out(pins.echo_timing_out),
    .pll_off_n(pins.pll_off_n));
  // clock generator
  initial begin
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  // prints counts and verdict
  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // old word with selected lanes replaced
  function automatic logic [DW-1:0] merge(logic [DW-1:0] o, logic [DW-1:0] n,
                                          logic [LN-1:0] s);
    for (int l = 0; l < LN; l++) begin
      if (!s[l]) o[l*B2DS_LANE_W +: B2DS_LANE_W] = n[l*B2DS_LANE_W +: B2DS_LANE_W];
    end
    return o;
  endfunction
  // one request, then the wire is checked
  task automatic do_req(input logic rd, input logic [B2DS_ADDR_W-1:0] a,
                        input logic [2*DW-1:0] wd, input logic [2*LN-1:0] ws);
    int n;
    n = 0;
    // let an edge pass, so valid is never lowered and raised in one step
    @(posedge clk);
    #2;
    req_read = rd;
    req_addr = a;
    req_wdata = wd;
    req_wsel_n = ws;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #2;
      n++;
    end
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    `CHK("load", 1'b0, pins.cycle_start_n)
    `CHK("dir", rd, pins.access_dir)
    `CHK("addr", a, pins.addr)
    if (!rd) begin
      `CHK("word0", wd[DW-1:0], pins.dq)
      `CHK("sel0", ws[LN-1:0], pins.byte_lane_wr_sel_n)
      @(posedge clk);
      #2;
      `CHK("word1", wd[2*DW-1:DW], pins.dq)
      `CHK("sel1", ws[2*LN-1:LN], pins.byte_lane_wr_sel_n)
    end
  endtask
  // pops one read word and compares it
  task automatic get_word(input logic [DW-1:0] e);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    `CHK("rd_data", e, rd_data)
    @(posedge clk);
    #2;
  endtask
  // write address 5 with selects, read it back
  task automatic wr_rd(input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                       input logic [2*LN-1:0] s);
    do_req(1'b0, 8'h05, {d1, d0}, s);
    mem0 = merge(mem0, d0, s[LN-1:0]);
    mem1 = merge(mem1, d1, s[2*LN-1:LN]);
    do_req(1'b1, 8'h05, '0, '1);
    get_word(mem0);
    get_word(mem1);
  endtask
  // full write, then lane patterns, then no lanes
  task automatic s_lanes();
    logic [2*LN-1:0] tbl [4] = '{8'h00, 8'h5a, 8'ha5, 8'hff};
    `CHK("width", 36, $bits(pins.dq))
    for (int k = 0; k < 4; k++) begin
      wr_rd(36'ha_aaaa_aaaa ^ k, 36'h5_5555_5555 ^ k, tbl[k]);
    end
  endtask
  // legacy latency with pll off
  task automatic s_pll_off();
    pll_enable = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    wr_rd(36'h1_2345_6789, 36'hf_edcb_a987, 8'h00);
    pll_enable = 1'b1;
    repeat (4) @(posedge clk);
    #2;
  endtask
  // fill the read fifo until refused, then drain
  task automatic s_fifo();
    logic seen;
    rd_ready = 1'b0;
    repeat (8) do_req(1'b1, 8'h05, '0, '1);
    repeat (12) @(posedge clk);
    #2;
    seen = 1'b0;
    req_valid = 1'b1;
    repeat (20) begin
      @(posedge clk);
      #2;
      seen |= req_ready;
    end
    req_valid = 1'b0;
    `CHK("full_refuse", 1'b0, seen)
    rd_ready = 1'b1;
    repeat (8) begin
      get_word(mem0);
      get_word(mem1);
    end
    `CHK("empty", 1'b0, rd_valid)
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    s_lanes();
    s_pll_off();
    s_fifo();
    give_verdict();
  end
endmodule // testbench

//--- verilog/b2ds_ctrl.sv
`timescale 1ns/1ps
// controller end: turns user requests into two-word bursts
module b2ds_ctrl #(
  parameter int DATA_W = b2ds_pkg::B2DS_DATA_W_WIDE,
  parameter int ADDR_W = b2ds_pkg::B2DS_ADDR_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   pll_enable,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_read,
  input  wire logic [ADDR_W-1:0]      req_addr,
  input  wire logic [2*DATA_W-1:0]    req_wdata,
  input  wire logic [2*DATA_W/9-1:0]  req_wsel_n,
  output logic                        rd_valid,
  input  wire logic                   rd_ready,
  output logic      [DATA_W-1:0]      rd_data,
  b2ds_if.ctrl                        pins
);
  import b2ds_pkg::*;
  localparam int LANES = DATA_W / B2DS_LANE_W;
  localparam int RW    = $clog2(B2DS_FIFO_DEPTH) + 1;  // room counter width

  // controller state
  typedef struct packed {
    b2ds_ctl_state_type        fsm;
    logic                      phase;
    logic                      ld_n;
    logic                      dir;
    logic [ADDR_W-1:0]         addr;
    logic [LANES-1:0]          sel_n;
    logic [DATA_W-1:0]         dout;
    logic                      oe;
    logic [DATA_W-1:0]         word2;
    logic [LANES-1:0]          sel2_n;
    logic [1:0]                rd_left;
    logic [1:0]                sync_vld;
    logic [DATA_W-1:0]         cap;
    logic                      cap_vld;
    logic [RW-1:0]             room;     // fifo places not yet promised
  } b2ds_ctl_full_type;

  b2ds_ctl_full_type st;       // registered state
  b2ds_ctl_full_type next_st;  // next state
  logic fifo_ready;            // room for read words
  logic can_issue;             // new request may load

  // issue in the inverted-edge slot, so the registered load stands on the pins
  // in the main-edge slot, and only while both read words are sure of a place
  assign can_issue = ce && st.fsm == B2DS_IDLE && st.phase && fifo_ready &&
                     st.room >= RW'(B2DS_BURST_LEN);
  assign req_ready = can_issue;

  // sequencer
  always_comb begin
    next_st = st;
    next_st.phase   = !st.phase;
    next_st.ld_n    = 1'b1;
    next_st.cap_vld = 1'b0;
    next_st.sync_vld = {st.sync_vld[0], pins.out_valid_flag};
    case (st.fsm)
      B2DS_IDLE: begin
        next_st.oe    = 1'b0;
        next_st.sel_n = '1;
        if (can_issue && req_valid) begin
          next_st.ld_n = 1'b0;
          next_st.dir  = req_read;
          next_st.addr = req_addr;
          if (req_read) begin
            next_st.rd_left = 2'd2;
            next_st.fsm     = B2DS_RDWAIT;
          end else begin
            next_st.dout   = req_wdata[DATA_W-1:0];
            next_st.sel_n  = req_wsel_n[LANES-1:0];
            next_st.word2  = req_wdata[2*DATA_W-1:DATA_W];
            next_st.sel2_n = req_wsel_n[2*LANES-1:LANES];
            next_st.oe     = 1'b1;
            next_st.fsm    = B2DS_WR2;
          end
        end
      end
      B2DS_WR2: begin
        next_st.dout  = st.word2;
        next_st.sel_n = st.sel2_n;
        next_st.oe    = 1'b1;
        next_st.fsm   = B2DS_IDLE;
      end
      B2DS_RDWAIT: begin
        next_st.oe = 1'b0;
        if (st.sync_vld[1]) begin
          next_st.rd_left = st.rd_left - 2'd1;
          if (st.rd_left == 2'd1) next_st.fsm = B2DS_IDLE;
        end
      end
      default: next_st.fsm = B2DS_IDLE;
    endcase
    // capture each read word in the cycle it stands, with its flag
    next_st.cap = pins.dq;
    next_st.cap_vld = pins.out_valid_flag;
    // a read takes room for its two words at issue, a pop gives one back
    if (can_issue && req_valid && req_read) begin
      next_st.room = next_st.room - RW'(B2DS_BURST_LEN);
    end
    if (rd_valid && rd_ready) begin
      next_st.room = next_st.room + RW'(1);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st       <= '0;
      st.fsm   <= B2DS_IDLE;
      st.ld_n  <= 1'b1;
      st.sel_n <= '1;
      st.room  <= RW'(B2DS_FIFO_DEPTH);
    end else if (ce) begin
      st <= next_st;
    end
  end

  // read data buffer, back-pressure holds off new requests
  b2ds_fifo #(.WIDTH(DATA_W), .DEPTH(B2DS_FIFO_DEPTH)) i_b2ds_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (st.cap_vld),
    .in_ready  (fifo_ready),
    .in_data   (st.cap),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // pin drive
  assign pins.cycle_start_n      = st.ld_n;
  assign pins.access_dir         = st.dir;
  assign pins.addr               = st.addr;
  assign pins.byte_lane_wr_sel_n = st.sel_n;
  assign pins.half_phase         = st.phase;
  assign pins.dq_ctl_o           = st.dout;
  assign pins.dq_ctl_oe_n        = !st.oe;
  assign pins.pll_off_n          = pll_enable;
endmodule : b2ds_ctrl

//--- verilog/b2ds_device.sv
`timescale 1ns/1ps
// Functional notes
// - write data sampled on both clock edges
// - read data driven on both edges
// - outputs released when no read selected
// - data bus 18 or 36 bits
// - low load strobe starts operation
// - every burst moves exactly two words
// - active-low lane selects sampled per word
// - each select gates nine data bits
// - selects arrive with their data word
// - deselected lanes keep stored byte
// - one address sampled at main edge
// - storage split into two word arrays
// - controller may permute address bits
// - direction high reads, low writes
// - first read word after 2.5 cycles
// - valid flag marks read data cycles
// - pll off gives shorter legacy latency
// - echo clock runs free, follows input
//
// the device runs on clk at half-cycle granularity: each clk cycle is one
// edge of the input clock pair, with half_phase telling main from inverted.
// a load only counts while half_phase is low, that is on a main edge; the
// first write word rides on that same edge and the second on the inverted
// edge after it. a read load launches two slots into the latency line, the
// second one half cycle behind the first, so the two words leave on two
// neighbouring edges and the valid flag stands for exactly those two.
// deselected lanes are simply not written: the array keeps its old slice.
// the arrays are not reset, so their content is unknown until written.
// the pll mode picks the latency tap; change it only while no read is in
// flight, or a word may leave twice or not at all.
module b2ds_device #(
  parameter int DATA_W = b2ds_pkg::B2DS_DATA_W_WIDE,
  parameter int ADDR_W = b2ds_pkg::B2DS_ADDR_W
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  b2ds_if.device    pins
);
  import b2ds_pkg::*;

  localparam int LANES = DATA_W / B2DS_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // refuse widths the lane logic cannot serve; checked at elaboration so a
  // wrong width never reaches simulation with lanes half wired
  // width check
  if (DATA_W != B2DS_DATA_W_WIDE && DATA_W != B2DS_DATA_W_NARROW) begin : g_bad_width
    $error("b2ds_device: data width must be 18 or 36");
  end
  // the arrays grow with two to the address width; keep it sane
  if (ADDR_W < 1 || ADDR_W > 20) begin : g_bad_addr
    $error("b2ds_device: address width out of range");
  end

  // read pipeline entry: valid, word index, address
  typedef struct packed {
    logic              vld;
    logic              word;
    logic [ADDR_W-1:0] addr;
  } b2ds_rd_slot_type;

  // whole state of the device; the arrays sit beside it as memories
  typedef struct packed {
    logic                     wr_act;    // second write word pending
    logic [ADDR_W-1:0]        wr_addr;   // latched write address
    // each slot moves one place per half cycle
    b2ds_rd_slot_type [B2DS_RD_LAT_HALF:0] rd_pipe; // read latency line
    logic [DATA_W-1:0]        q;         // output register
    logic                     q_oe;      // output drive active
    logic                     echo;      // echo clock
  } b2ds_dev_state_type;

  b2ds_dev_state_type st;       // registered state
  b2ds_dev_state_type next_st;  // next state

  // read words assembled from the per-lane slices of the two arrays
  // both are plain nets of the lane arrays, no extra register
  logic [DATA_W-1:0] rd_even;  // first word at the tapped address
  logic [DATA_W-1:0] rd_odd;   // second word at the tapped address

  // load strobe seen on a main edge
  logic load;
  // write word strobe and its index
  logic wr_now;
  logic wr_word;
  logic [ADDR_W-1:0] wr_at;
  // latency tap chosen by pll mode
  b2ds_rd_slot_type tap;

  // pll on or legacy latency tap
  // with the pll on a word leaves the line after five half cycles, with it
  // off after two; the tap only selects, it never delays further
  assign tap = pins.pll_off_n ? st.rd_pipe[B2DS_RD_LAT_HALF-1]
                              : st.rd_pipe[B2DS_RD_LAT_HALF_OFF-1];

  // load on main
  // a low strobe seen with half_phase high is ignored, and an edge with the
  // strobe high starts nothing while a running burst goes on
  assign load = ce && !pins.half_phase && !pins.cycle_start_n;

  // state update logic
  always_comb begin
    // defaults: hold state, no array write
    next_st = st;
    wr_now  = 1'b0;
    wr_word = 1'b0;
    wr_at   = st.wr_addr;
    next_st.echo = pins.half_phase;
    // shift the read latency line every half cycle
    next_st.rd_pipe = {st.rd_pipe[B2DS_RD_LAT_HALF-1:0], b2ds_rd_slot_type'('0)};
    if (st.wr_act) begin
      wr_now  = 1'b1;
      wr_word = 1'b1;
      next_st.wr_act = 1'b0;
    end
    // new operation taken on a main edge
    if (load) begin
      if (pins.access_dir) begin
        // two read slots
        // word 0 enters now, word 1 joins one half cycle later
        next_st.rd_pipe[0] = '{vld: 1'b1, word: 1'b0, addr: pins.addr};
      end else begin
        next_st.wr_addr = pins.addr;
        next_st.wr_act  = 1'b1;
        wr_now  = 1'b1;
        wr_word = 1'b0;
        wr_at   = pins.addr;
      end
    end
    // second read word follows one half cycle later
    if (st.rd_pipe[0].vld && !st.rd_pipe[0].word) begin
      next_st.rd_pipe[1] = st.rd_pipe[0];
      next_st.rd_pipe[0] = '{vld: 1'b1, word: 1'b1, addr: st.rd_pipe[0].addr};
    end
    // latency tap
    // the word goes out on the edge after the tap sees it, so the first word
    // is driven five half cycles after its load edge with the pll on, two with it off
    if (tap.vld) begin
      // odd slot reads the second array, even slot the first
      next_st.q    = tap.word ? rd_odd : rd_even;
      next_st.q_oe = 1'b1;
    end else begin
      // release bus
      // nothing due: release so the controller may drive
      next_st.q    = '0;
      next_st.q_oe = 1'b0;
    end
  end

  // state register, frozen while ce low
  always_ff @(posedge clk) begin
    if (rst) begin
      // idle: bus released, latency line empty, echo at rest
      st      <= '0;
      st.echo <= B2DS_ECHO_RST;
    end else if (ce) begin
      // advance one half cycle
      st <= next_st;
    end
  end

  // nine-bit lanes
  // each lane owns its slice of both arrays, so every slice has one writer
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [B2DS_LANE_W-1:0] array_even [DEPTH];  // first word of each burst
    logic [B2DS_LANE_W-1:0] array_odd  [DEPTH];  // second word of each burst

    // lane slice of the two words at the tapped address
    assign rd_even[l*B2DS_LANE_W +: B2DS_LANE_W] = array_even[tap.addr];
    assign rd_odd[l*B2DS_LANE_W +: B2DS_LANE_W]  = array_odd[tap.addr];

    // lane write, frozen with ce and idle in reset
    always_ff @(posedge clk) begin
      if (ce && !rst && wr_now && !pins.byte_lane_wr_sel_n[l]) begin
        // word index picks the array
        if (wr_word) begin
          array_odd[wr_at] <= pins.dq[l*B2DS_LANE_W +: B2DS_LANE_W];
        end else begin
          array_even[wr_at] <= pins.dq[l*B2DS_LANE_W +: B2DS_LANE_W];
        end
      end
    end
  end

  // pin outputs, all straight from the state register
  assign pins.dq_dev_o        = st.q;
  // enable low only while a read word stands
  assign pins.dq_dev_oe_n     = !st.q_oe;
  assign pins.out_valid_flag  = st.q_oe;
  assign pins.echo_timing_out = st.echo;
endmodule : b2ds_device

//--- verilog/b2ds_fifo.sv
`timescale 1ns/1ps
// synchronous fifo with valid/ready on both sides
module b2ds_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = b2ds_pkg::B2DS_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import b2ds_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // refuse depths the wrapping pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("b2ds_fifo: depth must be power of two");
  end

  // pointers and count
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } b2ds_fifo_state_type;

  b2ds_fifo_state_type st;       // registered pointers
  b2ds_fifo_state_type next_st;  // next pointers
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic push;                    // word accepted
  logic pop;                     // word leaves

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = mem[st.rp];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // pointer update
  always_comb begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop)  next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // pointer register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push && !rst) begin
      mem[st.wp] <= in_data;
    end
  end
endmodule : b2ds_fifo
